// ### core/fdc_pkg.sv
package fdc_pkg;
   // Command operations delivered by the supply demodulator
   typedef enum logic [1:0] {
      FDC_OP_READ  = 2'h0,
      FDC_OP_WRITE = 2'h1,
      FDC_OP_LOCK  = 2'h3
   } fdc_op_e;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   // One decoded command from the supply modulation framer
   typedef struct packed {
      fdc_op_e             op;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } fdc_cmd_s;

   // Setting indices on the command address
   localparam logic [ADDR_W-1:0] IDX_MODE  = 4'h0;
   localparam logic [ADDR_W-1:0] IDX_LTC   = 4'h1;
   localparam logic [ADDR_W-1:0] IDX_QTC   = 4'h2;
   localparam logic [ADDR_W-1:0] IDX_GAIN  = 4'h3;
   localparam logic [ADDR_W-1:0] IDX_OFFS  = 4'h4;
   localparam logic [ADDR_W-1:0] IDX_FLOOR = 4'h5;
   localparam logic [ADDR_W-1:0] IDX_CEIL  = 4'h6;
   localparam logic [ADDR_W-1:0] IDX_LOCK  = 4'h7;
   localparam logic [ADDR_W-1:0] IDX_RAW   = 4'h8;

   // Setup word fields
   localparam int RANGE_LSB = 0;
   localparam int FILT_LSB  = 3;
   localparam int SEL_W     = 3;
   localparam logic [2:0] FILT_MAX_CODE = 3'h4;
   localparam logic [2:0] FILT_FALLBACK = 3'h4;

   // Symmetric spans in mT indexed by span code
   localparam logic [7:0] SPAN_MT [0:7] = '{8'h1E, 8'h4B, 8'h5A, 8'h96,
                                            8'h28, 8'h3C, 8'h50, 8'h64};

   // Datapath widths and scaling: duty unit is 100% / 2048
   localparam int RAW_W   = 14;
   localparam int GAIN_W  = 15;
   localparam int OFFS_W  = 11;
   localparam int DUTY_W  = 12;
   localparam int GAIN_SH = 11;
   localparam logic [DUTY_W-1:0] DUTY_FULL = 12'h800;

   // Reset values
   localparam logic [5:0]        RST_MODE  = 6'h00;
   localparam logic [GAIN_W-1:0] RST_GAIN  = 15'h0800;
   localparam logic [OFFS_W-1:0] RST_OFFS  = 11'h000;
   localparam logic [10:0]       RST_FLOOR = 11'h000;
   localparam logic [DUTY_W-1:0] RST_CEIL  = 12'h800;

   // Cycles after reset release during which the stored lock is sampled
   localparam logic [1:0] BOOT_CYC = 2'h3;
endpackage : fdc_pkg

// ### core/fdc_core.sv
`timescale 1ns/1ps
module fdc_core
   import fdc_pkg::*;
#(
   parameter int LTC_W = 10,
   parameter int QTC_W = 8
) (
   // Clock and power-up reset
   input  wire logic                 CLK,
   input  wire logic                 SYS_RST,
   // Filtered converter sample
   input  wire logic                 RAW_VALID,
   input  wire logic [RAW_W-1:0]     RAW_SAMPLE,
   // Commands from the supply demodulator
   input  wire logic                 COMM_ACTIVE,
   input  wire logic                 CMD_VALID,
   input  wire fdc_cmd_s             CMD,
   // Nonvolatile lock cell
   input  wire logic                 LOCK_NV_IN,
   output logic                      LOCK_NV_SET,
   // Digital answer on the output pin
   output logic                      RESP_VALID,
   output logic [DATA_W-1:0]         RESP_DATA,
   // Analog front end controls
   output logic [SEL_W-1:0]          RANGE_SEL,
   output logic [7:0]                SPAN_MT_VAL,
   output logic [SEL_W-1:0]          CORNER_SEL,
   output logic [LTC_W-1:0]          LIN_TEMP_COEF,
   output logic [QTC_W-1:0]          QUAD_TEMP_COEF,
   // Duty to the PWM generator
   output logic                      PWM_EN,
   output logic [DUTY_W-1:0]         DUTY,
   output logic                      LOCKED
);

   logic [5:0]           mode_q;
   logic [LTC_W-1:0]     ltc_q;
   logic [QTC_W-1:0]     qtc_q;
   logic [GAIN_W-1:0]    gain_q;
   logic [OFFS_W-1:0]    offs_q;
   logic [10:0]          floor_q;
   logic [DUTY_W-1:0]    ceil_q;
   logic [RAW_W-1:0]     raw_q;
   logic                 lock_set_q;
   logic                 lock_eff_q;
   logic                 nv_s1_q;
   logic                 nv_s2_q;
   logic [1:0]           boot_q;
   logic                 resp_valid_q;
   logic [DATA_W-1:0]    resp_data_q;
   logic                 pwm_en_q;
   logic [DUTY_W-1:0]    duty_q;
   logic [SEL_W-1:0]     corner_q;
   logic [7:0]           span_q;
   logic                 cmd_ok;
   logic                 wr_en;
   logic [DATA_W-1:0]    rd_data;
   logic [DUTY_W-1:0]    duty_d;

   ////////////////////////////////////////////////////////////////////////////
   // Command acceptance: a stored lock drops every command on the floor
   assign cmd_ok = CMD_VALID && !lock_eff_q;
   assign wr_en  = cmd_ok && (CMD.op == FDC_OP_WRITE);

   ////////////////////////////////////////////////////////////////////////////
   // Lock cell synchroniser; the cell output is not on our clock
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         nv_s1_q <= 1'b0;
         nv_s2_q <= 1'b0;
      end else begin
         nv_s1_q <= LOCK_NV_IN;
         nv_s2_q <= nv_s1_q;
      end
   end

   // Boot window: the stored lock is sampled only in the first BOOT_CYC cycles after power-up,
   // so a lock set in this session never bites until the next power cycle
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         boot_q     <= 2'h0;
         lock_eff_q <= 1'b0;
      end else if (boot_q != BOOT_CYC) begin
         boot_q     <= boot_q + 2'h1;
         lock_eff_q <= nv_s2_q;
      end
   end

   // Lock request: set-only, no path clears it short of power loss,
   // and the cell itself keeps it across that
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         lock_set_q <= 1'b0;
      end else if (nv_s2_q || (cmd_ok && CMD.op == FDC_OP_LOCK)) begin
         lock_set_q <= 1'b1;
      end else if (cmd_ok && CMD.op == FDC_OP_WRITE && CMD.addr == IDX_LOCK
                   && CMD.data[0]) begin
         lock_set_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings; writes land only while unlocked, as often as wanted
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mode_q  <= RST_MODE;
         ltc_q   <= '0;
         qtc_q   <= '0;
         gain_q  <= RST_GAIN;
         offs_q  <= RST_OFFS;
         floor_q <= RST_FLOOR;
         ceil_q  <= RST_CEIL;
      end else if (wr_en) begin
         unique case (CMD.addr)
            IDX_MODE:  mode_q  <= CMD.data[5:0];
            IDX_LTC:   ltc_q   <= CMD.data[LTC_W-1:0];
            IDX_QTC:   qtc_q   <= CMD.data[QTC_W-1:0];
            IDX_GAIN:  gain_q  <= CMD.data[GAIN_W-1:0];
            IDX_OFFS:  offs_q  <= CMD.data[OFFS_W-1:0];
            IDX_FLOOR: floor_q <= (CMD.data[10:0] > 11'h400) ?
                                  11'h400 : CMD.data[10:0];
            IDX_CEIL:  ceil_q  <= (CMD.data[DUTY_W-1:0] > DUTY_FULL) ?
                                  DUTY_FULL : CMD.data[DUTY_W-1:0];
            default:   ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Raw sample holder, taken ahead of gain, offset and clamp
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         raw_q <= '0;
      end else if (RAW_VALID) begin
         raw_q <= RAW_SAMPLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Readback mux; unmapped indices answer zero
   always_comb begin
      rd_data = '0;
      unique case (CMD.addr)
         IDX_MODE:  rd_data[5:0]        = mode_q;
         IDX_LTC:   rd_data[LTC_W-1:0]  = ltc_q;
         IDX_QTC:   rd_data[QTC_W-1:0]  = qtc_q;
         IDX_GAIN:  rd_data[GAIN_W-1:0] = gain_q;
         IDX_OFFS:  rd_data[OFFS_W-1:0] = offs_q;
         IDX_FLOOR: rd_data[10:0]       = floor_q;
         IDX_CEIL:  rd_data[DUTY_W-1:0] = ceil_q;
         IDX_LOCK:  rd_data[0]          = lock_set_q;
         IDX_RAW:   rd_data[RAW_W-1:0]  = raw_q;
         default:   rd_data             = '0;
      endcase
   end

   // Answer on the output pin; writes and lock are acknowledged by echo
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         resp_valid_q <= 1'b0;
         resp_data_q  <= '0;
      end else begin
         resp_valid_q <= cmd_ok;
         if (cmd_ok) begin
            resp_data_q <= (CMD.op == FDC_OP_READ) ? rd_data : CMD.data;
         end
      end
   end

   // PWM is held off for the whole exchange while unlocked; once locked it keeps running
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pwm_en_q <= 1'b0;
      end else begin
         pwm_en_q <= !(COMM_ACTIVE && !lock_eff_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Front end selects; reserved corner codes take the fastest filter
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         corner_q <= '0;
         span_q   <= SPAN_MT[0];
      end else begin
         span_q   <= SPAN_MT[mode_q[RANGE_LSB +: SEL_W]];
         corner_q <= (mode_q[FILT_LSB +: SEL_W] > FILT_MAX_CODE) ?
                     FILT_FALLBACK : mode_q[FILT_LSB +: SEL_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Duty arithmetic in 1/2048 units. The product is kept full width so
   // the extreme gain with a saturated sample cannot wrap
   always_comb begin
      logic signed [RAW_W+GAIN_W-1:0] prod;
      logic signed [19:0]             sum;
      logic signed [19:0]             top;
      prod = $signed(raw_q) * $signed(gain_q);
      sum  = 20'(prod >>> GAIN_SH)
           + 20'($signed({offs_q, 1'b0}));
      top  = 20'($signed({1'b0, DUTY_FULL}));
      if (offs_q[OFFS_W-1]) begin
         top = 20'($signed({offs_q, 1'b0})) + top;
      end
      if (sum > top) begin
         sum = top;
      end
      if (sum < 20'($signed({1'b0, floor_q}))) begin
         sum = 20'($signed({1'b0, floor_q}));
      end
      // Ceiling applied after the floor, so it wins if set below the floor
      if (sum > 20'($signed({1'b0, ceil_q}))) begin
         sum = 20'($signed({1'b0, ceil_q}));
      end
      if (sum < 20'sh0) begin
         sum = 20'sh0;
      end
      duty_d = sum[DUTY_W-1:0];
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         duty_q <= '0;
      end else begin
         duty_q <= duty_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign RESP_VALID     = resp_valid_q;
   assign RESP_DATA      = resp_data_q;
   assign RANGE_SEL      = mode_q[RANGE_LSB +: SEL_W];
   assign SPAN_MT_VAL    = span_q;
   assign CORNER_SEL     = corner_q;
   assign LIN_TEMP_COEF  = ltc_q;
   assign QUAD_TEMP_COEF = qtc_q;
   assign PWM_EN         = pwm_en_q;
   assign DUTY           = duty_q;
   assign LOCKED         = lock_eff_q;
   assign LOCK_NV_SET    = lock_set_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   lock_sticky_a: assert property (lock_set_q |=> lock_set_q)
      else $error("lock request cleared");
   lock_deferred_a: assert property (
      (boot_q == BOOT_CYC && !lock_eff_q) |=> !lock_eff_q)
      else $error("lock took effect without power cycle");
   locked_silent_a: assert property (lock_eff_q |=> !resp_valid_q)
      else $error("locked device answered");
   locked_frozen_a: assert property (
      lock_eff_q |=> $stable(gain_q) && $stable(offs_q) && $stable(mode_q))
      else $error("setting changed while locked");
   raw_read_a: assert property (
      (cmd_ok && CMD.op == FDC_OP_READ && CMD.addr == IDX_RAW)
      |=> resp_valid_q && resp_data_q[RAW_W-1:0] == $past(raw_q))
      else $error("raw readback mismatch");
   duty_floor_a: assert property (
      ({1'b0, floor_q} <= ceil_q) |=> duty_q >= 12'($past(floor_q)))
      else $error("duty below floor");
   duty_ceil_a: assert property (1'b1 |=> duty_q <= $past(ceil_q))
      else $error("duty above ceiling");
   pwm_off_a: assert property (
      (COMM_ACTIVE && !lock_eff_q) |=> !pwm_en_q)
      else $error("pwm ran during exchange");
   corner_fallback_a: assert property (
      (mode_q[FILT_LSB +: SEL_W] > FILT_MAX_CODE) |=> corner_q == FILT_FALLBACK)
      else $error("reserved corner not replaced");
   span_map_a: assert property (
      (mode_q[RANGE_LSB +: SEL_W] == 3'h3) |=> span_q == 8'h96)
      else $error("span code 3 not 150 mT");
   lock_request_a: assert property (
      (cmd_ok && CMD.op == FDC_OP_LOCK) |=> lock_set_q)
      else $error("lock command not recorded");
   write_echo_a: assert property (
      (cmd_ok && CMD.op == FDC_OP_WRITE) |=> resp_valid_q && resp_data_q == $past(CMD.data))
      else $error("write not acknowledged");

endmodule : fdc_core

// ### testbench/fdc_prog.sv
`timescale 1ns/1ps
// Programmer on the far side, sending demodulated supply commands
module fdc_prog
   import fdc_pkg::*;
(
   // Clock
   input  wire logic              clk,
   // Command side
   output logic                   comm_active,
   output logic                   cmd_valid,
   output fdc_cmd_s               cmd,
   // Answer side
   input  wire logic              resp_valid,
   input  wire logic [DATA_W-1:0] resp_data
);
   initial begin
      comm_active = 1'b0;
      cmd_valid   = 1'b0;
      cmd         = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One exchange; gap idles with the supply modulated, as a slow programmer
   task automatic send(input fdc_op_e op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input int gap,
                       output logic ok, output logic [DATA_W-1:0] rd);
      @(posedge clk);
      comm_active <= 1'b1;
      repeat (gap) @(posedge clk);
      cmd_valid <= 1'b1;
      cmd       <= '{op: op, addr: a, data: d};
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd       <= ~cmd;   // Released bus must not look like a held value
      #1;
      ok = resp_valid;
      rd = resp_data;
      @(posedge clk);
      comm_active <= 1'b0;
   endtask : send
   // Modulation without a command, to watch the PWM hold off
   task automatic set_comm(input logic b);
      @(posedge clk);
      comm_active <= b;
   endtask : set_comm
   // Two point calibration; targets and readings in 1/2048 of full duty,
   // gain returned in 1/2048 steps and offset in 1/1024 steps
   function automatic void calibrate(input int r1, input int r2, input int d1, input int d2,
                                     output logic [DATA_W-1:0] g,
                                     output logic [DATA_W-1:0] o);
      int gc;
      gc = (32'sh800 * (d2 - d1)) / (r2 - r1);
      g  = DATA_W'(gc);
      o  = DATA_W'((d1 - (r1 * gc) / 32'sh800) / 32'sh2);
   endfunction : calibrate
endmodule : fdc_prog

// ### testbench/field_to_duty_conditioning_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the conditioning path
module field_to_duty_conditioning_bench
   import fdc_pkg::*;
   ;
   typedef struct packed {
      logic [RAW_W-1:0]  raw;
      logic [GAIN_W-1:0] gain;
      logic [OFFS_W-1:0] offs;
      logic [10:0]       flr;
      logic [11:0]       ceil;
      logic [DUTY_W-1:0] duty;
   } fdc_row_s;
   // Raw, gain, offset, floor, ceiling, expected duty
   localparam fdc_row_s ROWS [0:9] = '{
      '{14'h0400, 15'h0800, 11'h000, 11'h000, 12'h800, 12'h400},
      '{14'h0800, 15'h0800, 11'h000, 11'h000, 12'h800, 12'h800},
      '{14'h0000, 15'h0800, 11'h100, 11'h000, 12'h800, 12'h200},
      '{14'h0BB8, 15'h0800, 11'h700, 11'h000, 12'h800, 12'h600},
      '{14'h0000, 15'h0800, 11'h000, 11'h7FF, 12'h800, 12'h400},
      '{14'h0800, 15'h0800, 11'h000, 11'h000, 12'h600, 12'h600},
      '{14'h3F00, 15'h6000, 11'h000, 11'h000, 12'h800, 12'h400},
      '{14'h1000, 15'h0001, 11'h000, 11'h000, 12'h800, 12'h002},
      '{14'h3C00, 15'h0800, 11'h000, 11'h000, 12'h800, 12'h000},
      '{14'h0000, 15'h0800, 11'h000, 11'h400, 12'h100, 12'h100}};
   localparam logic [7:0] SPAN_EXP [0:7] = '{8'h1E, 8'h4B, 8'h5A, 8'h96,
                                             8'h28, 8'h3C, 8'h50, 8'h64};
   logic              CLK;
   logic              SYS_RST;
   logic              RAW_VALID;
   logic [RAW_W-1:0]  RAW_SAMPLE;
   logic              LOCK_NV_IN;
   logic              COMM_ACTIVE;
   logic              CMD_VALID;
   fdc_cmd_s          CMD;
   logic              LOCK_NV_SET;
   logic              RESP_VALID;
   logic [DATA_W-1:0] RESP_DATA;
   logic [SEL_W-1:0]  RANGE_SEL;
   logic [7:0]        SPAN_MT_VAL;
   logic [SEL_W-1:0]  CORNER_SEL;
   logic [9:0]        LIN_TEMP_COEF;
   logic [7:0]        QUAD_TEMP_COEF;
   logic              PWM_EN;
   logic [DUTY_W-1:0] DUTY;
   logic              LOCKED;
   logic              got_ok;
   logic [DATA_W-1:0] got_rd;
   int                err_count = 0;
   int                check_count = 0;
   int                gap_n = 0;
   int                cal_r1;
   int                cal_r2;
   logic [DATA_W-1:0] cal_g;
   logic [DATA_W-1:0] cal_o;
   ////////////////////////////////////////////////////////////////////////////
   // Device and programmer
   fdc_core fdc_core_inst (.CLK(CLK), .SYS_RST(SYS_RST), .RAW_VALID(RAW_VALID),
      .RAW_SAMPLE(RAW_SAMPLE), .COMM_ACTIVE(COMM_ACTIVE), .CMD_VALID(CMD_VALID),
      .CMD(CMD), .LOCK_NV_IN(LOCK_NV_IN), .LOCK_NV_SET(LOCK_NV_SET),
      .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA), .RANGE_SEL(RANGE_SEL),
      .SPAN_MT_VAL(SPAN_MT_VAL), .CORNER_SEL(CORNER_SEL),
      .LIN_TEMP_COEF(LIN_TEMP_COEF), .QUAD_TEMP_COEF(QUAD_TEMP_COEF),
      .PWM_EN(PWM_EN), .DUTY(DUTY), .LOCKED(LOCKED));
   fdc_prog fdc_prog_inst (.clk(CLK), .comm_active(COMM_ACTIVE), .cmd_valid(CMD_VALID),
      .cmd(CMD), .resp_valid(RESP_VALID), .resp_data(RESP_DATA));
   // 50 MHz clock
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Compares, one per kind of result
   task automatic chk_v(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_v
   task automatic chk_b(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_b
   // Write with echo check
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      fdc_prog_inst.send(FDC_OP_WRITE, a, d, gap_n, got_ok, got_rd);
      chk_b(got_ok, 1'b1);
      chk_v(got_rd, d);
   endtask : wr
   // One raw pulse, then wait until the duty has followed
   task automatic raw_in(input logic [RAW_W-1:0] v);
      @(posedge CLK);
      RAW_VALID  <= 1'b1;
      RAW_SAMPLE <= v;
      @(posedge CLK);
      RAW_VALID <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
   endtask : raw_in
   // Power cycle; the lock cell level is held steady from release on
   task automatic do_reset(input logic nv);
      @(posedge CLK);
      SYS_RST    <= 1'b1;
      LOCK_NV_IN <= nv;
      repeat (5) @(posedge CLK);
      #1;
      chk_b(PWM_EN, 1'b0);
      chk_v(16'(SPAN_MT_VAL), 16'h001E);
      @(posedge CLK);
      SYS_RST <= 1'b0;
      repeat (5) @(posedge CLK);
      #1;
   endtask : do_reset
   task automatic test_done;
      $display("Checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      SYS_RST    = 1'b1;
      RAW_VALID  = 1'b0;
      RAW_SAMPLE = '0;
      LOCK_NV_IN = 1'b0;
      do_reset(1'b0);
      for (int i = 0; i < 10; i++) begin
         gap_n = i % 3;
         wr(IDX_GAIN, 16'(ROWS[i].gain));
         wr(IDX_OFFS, 16'(ROWS[i].offs));
         wr(IDX_FLOOR, 16'(ROWS[i].flr));
         wr(IDX_CEIL, 16'(ROWS[i].ceil));
         raw_in(ROWS[i].raw);
         chk_v(16'(DUTY), 16'(ROWS[i].duty));
      end
      // Every span and corner code, reserved corners included
      for (int i = 0; i < 8; i++) begin
         wr(IDX_MODE, 16'({i[2:0], i[2:0]}));
         repeat (2) @(posedge CLK);
         #1;
         chk_v(16'(RANGE_SEL), 16'(i));
         chk_v(16'(SPAN_MT_VAL), 16'(SPAN_EXP[i]));
         chk_v(16'(CORNER_SEL), (i > 4) ? 16'h4 : 16'(i));
      end
      wr(IDX_LTC, 16'h03FF);
      wr(IDX_QTC, 16'h0081);
      chk_v(16'(LIN_TEMP_COEF), 16'h03FF);
      chk_v(16'(QUAD_TEMP_COEF), 16'h0081);
      // Readback comes before the gain stage
      raw_in(14'h2ABC);
      fdc_prog_inst.send(FDC_OP_READ, IDX_RAW, 16'h0000, 1, got_ok, got_rd);
      chk_v(16'(got_rd[13:0]), 16'h2ABC);
      fdc_prog_inst.send(FDC_OP_READ, 4'hF, 16'h0000, 0, got_ok, got_rd);
      chk_v(got_rd, 16'h0000);
      fdc_prog_inst.set_comm(1'b1);
      repeat (2) @(posedge CLK);
      #1;
      chk_b(PWM_EN, 1'b0);
      fdc_prog_inst.set_comm(1'b0);
      repeat (2) @(posedge CLK);
      #1;
      chk_b(PWM_EN, 1'b1);
      // Two point calibration; targets 12.5% and 87.5% lie inside the clamps
      wr(IDX_FLOOR, 16'h0080);
      wr(IDX_CEIL, 16'h0780);
      raw_in(14'h3D00);
      fdc_prog_inst.send(FDC_OP_READ, IDX_RAW, 16'h0000, 0, got_ok, got_rd);
      cal_r1 = int'($signed(got_rd[RAW_W-1:0]));
      raw_in(14'h0300);
      fdc_prog_inst.send(FDC_OP_READ, IDX_RAW, 16'h0000, 0, got_ok, got_rd);
      cal_r2 = int'($signed(got_rd[RAW_W-1:0]));
      fdc_prog_inst.calibrate(cal_r1, cal_r2, 32'h100, 32'h700, cal_g, cal_o);
      wr(IDX_GAIN, cal_g);
      wr(IDX_OFFS, cal_o);
      raw_in(14'h3D00);
      chk_v(16'(DUTY), 16'h0100);
      raw_in(14'h0300);
      chk_v(16'(DUTY), 16'h0700);
      // Lock through its register: a zero leaves it open, a one requests it
      wr(IDX_LOCK, 16'h0000);
      chk_b(LOCK_NV_SET, 1'b0);
      wr(IDX_LOCK, 16'h0001);
      chk_b(LOCK_NV_SET, 1'b1);
      fdc_prog_inst.send(FDC_OP_READ, IDX_LOCK, 16'h0000, 0, got_ok, got_rd);
      chk_v(got_rd, 16'h0001);
      // Power lost before the cell was written: the next session stays open
      do_reset(1'b0);
      chk_b(LOCKED, 1'b0);
      // Lock request, still open until the next power cycle
      fdc_prog_inst.send(FDC_OP_LOCK, 4'h0, 16'h0001, 0, got_ok, got_rd);
      chk_b(LOCK_NV_SET, 1'b1);
      chk_b(LOCKED, 1'b0);
      wr(IDX_GAIN, 16'h1000);
      do_reset(1'b1);
      chk_b(LOCKED, 1'b1);
      chk_b(LOCK_NV_SET, 1'b1);
      fdc_prog_inst.send(FDC_OP_WRITE, IDX_GAIN, 16'h1000, 0, got_ok, got_rd);
      chk_b(got_ok, 1'b0);
      raw_in(14'h0400);
      chk_v(16'(DUTY), 16'h0400);
      fdc_prog_inst.send(FDC_OP_READ, IDX_RAW, 16'h0000, 0, got_ok, got_rd);
      chk_b(got_ok, 1'b0);
      fdc_prog_inst.set_comm(1'b1);
      repeat (2) @(posedge CLK);
      #1;
      chk_b(PWM_EN, 1'b1);
      fdc_prog_inst.set_comm(1'b0);
      test_done;
   end
   // Watchdog, far beyond the expected run of a few hundred cycles
   initial begin
      #(20 * 20000);
      err_count++;
      $display("BAD %0t timeout", $time);
      test_done;
   end
endmodule : field_to_duty_conditioning_bench
